// *** src/adc_input_channel_select.sv ***
`timescale 1ns/1ps

module adc_input_channel_select
    import adc_mux_pkg::*;
(
    // Clock and reset
    input  wire logic                 REF_CLK_I,
    input  wire logic                 NRST_I,
    // Special-function register bus
    input  wire logic [7:0]           SFR_ADDR_I,
    input  wire logic [7:0]           SFR_WDATA_I,
    input  wire logic                 SFR_WR_I,
    output logic      [7:0]           SFR_RDATA_O,
    // Sensor enable bit from the reference control register
    input  wire logic                 TEMP_SENSOR_ENABLE_I,
    // Positive multiplexer select lines
    output logic [PIN_LINES-1:0]      POS_PIN_SEL_O,
    output logic                      POS_TEMP_SEL_O,
    output logic                      POS_SUPPLY_SEL_O,
    // Negative multiplexer select lines
    output logic [PIN_LINES-1:0]      NEG_PIN_SEL_O,
    output logic                      NEG_VREF_SEL_O,
    output logic                      NEG_GROUND_SEL_O,
    // Converter mode and sensor control
    output logic                      SINGLE_ENDED_O,
    output logic                      TEMP_SENSOR_ON_O,
    output logic                      TEMP_READING_VALID_O
);

    logic [CODE_W-1:0] positive_input_select;
    logic [CODE_W-1:0] negative_input_select;

    // One-hot pin line for codes 0..15 and 18..21; none elsewhere
    function automatic logic [PIN_LINES-1:0] pin_decode(
        input logic [CODE_W-1:0] code
    );
        logic [PIN_LINES-1:0] hot;
        hot = '0;
        if (code <= CODE_P1_LAST)
            hot[code[3:0]] = 1'b1;
        else if (code >= CODE_P2_FIRST && code <= CODE_P2_LAST)
            hot[5'(code - 5'h02)] = 1'b1;
        return hot;
    endfunction : pin_decode

    // Register decode; page register is ignored, both sit on all pages
    wire pos_wr = SFR_WR_I && (SFR_ADDR_I == POS_SEL_ADDR);
    wire neg_wr = SFR_WR_I && (SFR_ADDR_I == NEG_SEL_ADDR);

    // Read data; upper bits zero and unmapped addresses read zero
    wire [7:0] next_rdata =
        (SFR_ADDR_I == POS_SEL_ADDR) ? {3'h0, positive_input_select} :
        (SFR_ADDR_I == NEG_SEL_ADDR) ? {3'h0, negative_input_select} :
        8'h00;

    // Select decodes; codes 10110-11111 drive no line at all
    wire [PIN_LINES-1:0] next_pos_pins = pin_decode(positive_input_select);
    wire [PIN_LINES-1:0] next_neg_pins = pin_decode(negative_input_select);
    wire next_pos_temp = positive_input_select == CODE_TEMP;
    wire next_pos_vdd  = positive_input_select == CODE_SUPPLY;
    wire next_neg_vref = negative_input_select == CODE_VREF;
    wire next_neg_gnd  = negative_input_select == CODE_GROUND;
    // Sensor reading valid only single-ended with sensor powered
    wire next_valid = next_pos_temp && next_neg_gnd
                      && TEMP_SENSOR_ENABLE_I;

    // Positive code register; bits 7:5 of the write data are dropped
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            positive_input_select <= SEL_RESET;
        end
        else if (pos_wr)
        begin
            positive_input_select <= SFR_WDATA_I[4:0];
        end
    end

    // Negative code register; bits 7:5 of the write data are dropped
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            negative_input_select <= SEL_RESET;
        end
        else if (neg_wr)
        begin
            negative_input_select <= SFR_WDATA_I[4:0];
        end
    end

    // Read data lags the address by one cycle
    // Registered so the bus never sees a decode glitch
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            SFR_RDATA_O <= 8'h00;
        end
        else
        begin
            SFR_RDATA_O <= next_rdata;
        end
    end

    // Positive pin switches; one-hot so two pins never short together
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            POS_PIN_SEL_O <= '0;
        end
        else
        begin
            POS_PIN_SEL_O <= next_pos_pins;
        end
    end

    // Sensor switch onto the positive input
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            POS_TEMP_SEL_O <= 1'b0;
        end
        else
        begin
            POS_TEMP_SEL_O <= next_pos_temp;
        end
    end

    // Supply switch onto the positive input
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            POS_SUPPLY_SEL_O <= 1'b0;
        end
        else
        begin
            POS_SUPPLY_SEL_O <= next_pos_vdd;
        end
    end

    // Negative pin switches; same one-hot layout as the positive side
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            NEG_PIN_SEL_O <= '0;
        end
        else
        begin
            NEG_PIN_SEL_O <= next_neg_pins;
        end
    end

    // Reference switch onto the negative input
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            NEG_VREF_SEL_O <= 1'b0;
        end
        else
        begin
            NEG_VREF_SEL_O <= next_neg_vref;
        end
    end

    // Ground switch onto the negative input
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            NEG_GROUND_SEL_O <= 1'b0;
        end
        else
        begin
            NEG_GROUND_SEL_O <= next_neg_gnd;
        end
    end

    // Mode flag; unused codes report differential, as nothing is grounded
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            SINGLE_ENDED_O <= 1'b0;
        end
        else
        begin
            SINGLE_ENDED_O <= next_neg_gnd;
        end
    end

    // Sensor power; its output floats while this is low
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            TEMP_SENSOR_ON_O <= 1'b0;
        end
        else
        begin
            TEMP_SENSOR_ON_O <= TEMP_SENSOR_ENABLE_I;
        end
    end

    // Sensor reading usable only single-ended and powered
    // Lands on the same edge as the switches it depends on
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            TEMP_READING_VALID_O <= 1'b0;
        end
        else
        begin
            TEMP_READING_VALID_O <= next_valid;
        end
    end

endmodule : adc_input_channel_select

// *** shared/adc_mux_pkg.sv ***
package adc_mux_pkg;

    // Register map on the special-function bus
    localparam logic [7:0] NEG_SEL_ADDR = 8'hBA;
    localparam logic [7:0] POS_SEL_ADDR = 8'hBB;

    // Code field layout and reset value
    localparam int         CODE_W    = 5;
    localparam logic [4:0] SEL_RESET = 5'h1F;

    // Selection codes
    localparam logic [4:0] CODE_P1_LAST  = 5'h0F;
    localparam logic [4:0] CODE_TEMP     = 5'h10;
    localparam logic [4:0] CODE_SUPPLY   = 5'h11;
    localparam logic [4:0] CODE_VREF     = 5'h10;
    localparam logic [4:0] CODE_GROUND   = 5'h11;
    localparam logic [4:0] CODE_P2_FIRST = 5'h12;
    localparam logic [4:0] CODE_P2_LAST  = 5'h15;

    // Number of port pin select lines (P0, P1, P2[3:0])
    localparam int PIN_LINES = 20;

endpackage : adc_mux_pkg

// *** verif/adc_front_model.sv ***
`timescale 1ns/1ps
// Switch bank: two closed switches would short two inputs together
module adc_front_model
(
    input  logic [21:0] p_i, n_i,
    output logic [4:0]  pn_o, nn_o
);
    assign pn_o = 5'($countones(p_i));
    assign nn_o = 5'($countones(n_i));
endmodule : adc_front_model

// *** verif/adc_sel_chk.sv ***
`timescale 1ns/1ps
module adc_sel_chk
    import adc_mux_pkg::*;
(
    input logic REF_CLK_I, NRST_I, SFR_WR_I, TEMP_SENSOR_ENABLE_I,
    input logic [7:0] SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O,
    input logic [PIN_LINES-1:0] POS_PIN_SEL_O, NEG_PIN_SEL_O,
    input logic POS_TEMP_SEL_O, POS_SUPPLY_SEL_O, NEG_VREF_SEL_O,
    input logic NEG_GROUND_SEL_O, SINGLE_ENDED_O, TEMP_SENSOR_ON_O,
    input logic TEMP_READING_VALID_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);
    // Writes reach the select lines two edges later
    wire wp = SFR_WR_I && SFR_ADDR_I == POS_SEL_ADDR;
    wire wn = SFR_WR_I && SFR_ADDR_I == NEG_SEL_ADDR;
    wire [4:0] d = SFR_WDATA_I[4:0];
    // Own copy of the negative code, built from bus writes only
    logic [4:0] neg_shadow;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
        if (!NRST_I) neg_shadow <= SEL_RESET;
        else if (wn) neg_shadow <= d;
    pos_pin_a: assert property (wp && d <= CODE_P1_LAST |-> ##2
        POS_PIN_SEL_O == 20'h1 << $past(d, 2)) else $error("pin");
    pos_temp_a: assert property (wp && d == CODE_TEMP |-> ##2
        POS_TEMP_SEL_O && !POS_SUPPLY_SEL_O) else $error("temp");
    pos_none_a: assert property (wp && d > CODE_P2_LAST |-> ##2
        !POS_PIN_SEL_O && !POS_TEMP_SEL_O) else $error("none");
    neg_vref_a: assert property (wn && d == CODE_VREF |-> ##2
        NEG_VREF_SEL_O && !SINGLE_ENDED_O) else $error("vref");
    neg_gnd_a: assert property (wn && d == CODE_GROUND |-> ##2
        NEG_GROUND_SEL_O && SINGLE_ENDED_O) else $error("gnd");
    mode_tie_a: assert property (SINGLE_ENDED_O ==
        ($past(neg_shadow) == CODE_GROUND)) else $error("mode");
    reading_valid_a: assert property (TEMP_READING_VALID_O ==
        (POS_TEMP_SEL_O && NEG_GROUND_SEL_O && TEMP_SENSOR_ON_O))
        else $error("valid");
    neg_p2_a: assert property (wn && d inside {[5'h12:5'h15]} |-> ##2
        NEG_PIN_SEL_O == 20'h1 << ($past(d, 2) - 5'h2)) else $error("p2");
    sensor_on_a: assert property (1'b1 |=> TEMP_SENSOR_ON_O ==
        $past(TEMP_SENSOR_ENABLE_I)) else $error("sensor");
endmodule : adc_sel_chk

// *** verif/adc_input_channel_select_test.sv ***
`timescale 1ns/1ps
module adc_input_channel_select_test;
    import adc_mux_pkg::*;
    logic REF_CLK_I = 0, NRST_I = 0, SFR_WR_I = 0, TEMP_SENSOR_ENABLE_I = 0;
    logic [7:0] SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00, SFR_RDATA_O;
    logic [19:0] POS_PIN_SEL_O, NEG_PIN_SEL_O;
    logic POS_TEMP_SEL_O, POS_SUPPLY_SEL_O, NEG_VREF_SEL_O, NEG_GROUND_SEL_O;
    logic SINGLE_ENDED_O, TEMP_SENSOR_ON_O, TEMP_READING_VALID_O;
    logic [4:0] pn, nn;
    int n_fail = 0, n_tests = 0;
    integer seed = 32'hBE425FBA;
    always #50 REF_CLK_I = ~REF_CLK_I;
    adc_input_channel_select u_adc_input_channel_select (.*);
    adc_front_model u_adc_front_model (.p_i({POS_SUPPLY_SEL_O, POS_TEMP_SEL_O,
        POS_PIN_SEL_O}), .n_i({NEG_GROUND_SEL_O, NEG_VREF_SEL_O,
        NEG_PIN_SEL_O}), .pn_o(pn), .nn_o(nn));
    // Expected pattern {supply or ground, sensor or reference, pins}
    function automatic logic [21:0] sel(input logic [4:0] c);
        sel = 22'h0;
        if (c < 5'h10) sel[c] = 1'b1;
        else if (c == 5'h10) sel[20] = 1'b1;
        else if (c == 5'h11) sel[21] = 1'b1;
        else if (c < 5'h16) sel[c - 5'h2] = 1'b1;
    endfunction : sel
    task automatic chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) n_fail++;
        if (g !== e) $display("MISMATCH %0t %0h %0h", $time, g, e);
    endtask : chk
    // Back-to-back writes; bit 5 of a also steers the sensor enable
    task automatic step(input logic [7:0] a, b);
        TEMP_SENSOR_ENABLE_I = a[5];
        {SFR_ADDR_I, SFR_WDATA_I, SFR_WR_I} = {POS_SEL_ADDR, a, 1'b1};
        @(negedge REF_CLK_I) {SFR_ADDR_I, SFR_WDATA_I} = {NEG_SEL_ADDR, b};
        @(negedge REF_CLK_I) SFR_WR_I = 1'b0;
        @(negedge REF_CLK_I) chk(SFR_RDATA_O, {3'h0, b[4:0]});
        chk({POS_SUPPLY_SEL_O, POS_TEMP_SEL_O, POS_PIN_SEL_O},
            sel(a));
        chk({NEG_GROUND_SEL_O, NEG_VREF_SEL_O, NEG_PIN_SEL_O},
            sel(b));
        chk(SINGLE_ENDED_O, b[4:0] == 5'h11);
        chk(NEG_GROUND_SEL_O || !SINGLE_ENDED_O, 1'b1);
        chk(TEMP_SENSOR_ON_O, a[5]);
        chk(TEMP_READING_VALID_O, a[5:0] == 6'h30 && b[4:0] == 5'h11);
        chk({pn, nn}, {5'(a[4:0] < 5'h16), 5'(b[4:0] < 5'h16)});
    endtask : step
    initial
    begin
        repeat (10) @(negedge REF_CLK_I);
        chk({pn, nn, SINGLE_ENDED_O, TEMP_SENSOR_ON_O}, 12'h000);
        {NRST_I, SFR_ADDR_I} = {1'b1, POS_SEL_ADDR};
        @(negedge REF_CLK_I) chk(SFR_RDATA_O, 8'h1F);
        SFR_ADDR_I = 8'hBC;
        @(negedge REF_CLK_I) chk(SFR_RDATA_O, 8'h00);
        for (int i = 0; i < 32; i++) step({3'h7, 5'(i)}, {3'h5, 5'(31 - i)});
        step(8'h30, 8'h11);
        step(8'h10, 8'h11);
        repeat (300) step(8'($random(seed)), 8'($random(seed)));
        // Second reset at the end of the run
        NRST_I = 1'b0;
        @(negedge REF_CLK_I) chk({pn, nn, SINGLE_ENDED_O}, 11'h000);
        NRST_I = 1'b1;
        @(negedge REF_CLK_I) chk(SFR_RDATA_O, 8'h1F);
        final_report;
    end
    initial
    begin
        #1000000 n_fail++;
        final_report;
    end
    task automatic final_report;
        if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
endmodule : adc_input_channel_select_test
bind adc_input_channel_select adc_sel_chk u_adc_sel_chk (.*);
